//--- rtl/ctq_pkg.sv
package ctq_pkg;
  // ------------------------------------------------------------
  // Process image object indices
  // ------------------------------------------------------------
  localparam logic [15:0] IDX_OUT_STD = 16'h7000; // Std Tx queue
  localparam logic [15:0] IDX_OUT_EXT = 16'h7001; // Ext Tx queue
  localparam logic [15:0] IDX_IN_STD  = 16'h6000; // Std input side
  localparam logic [15:0] IDX_IN_EXT  = 16'h6001; // Ext input side

  // ------------------------------------------------------------
  // Sub-indices
  // ------------------------------------------------------------
  localparam logic [7:0] SUB_COUNT = 8'h00; // Entry count
  localparam logic [7:0] SUB_CNT1  = 8'h01; // Tx counter
  localparam logic [7:0] SUB_CNT2  = 8'h02; // Rx counter
  localparam logic [7:0] SUB_BATCH = 8'h03; // Batch size
  localparam logic [7:0] SUB_SLOT0 = 8'h04; // First slot
  localparam logic [7:0] SUB_TXN   = 8'h04; // Input side txn

  // ------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------
  localparam int SLOT_DEPTH = 32;  // Slot storage depth
  localparam int SLOT_AW    = 5;   // Slot index width
  localparam int FIFO_DEPTH = 32;  // Send FIFO depth
  localparam int FRAME_W    = 115; // Normalised frame width
  localparam logic [7:0] SLOT_DEPTH_8 = 8'h20; // Depth as byte
  localparam logic [15:0] DLC_MAX = 16'h0008;  // Longest payload

  // ------------------------------------------------------------
  // Slot layouts
  // ------------------------------------------------------------
  localparam int SS_DLC_LSB = 16; // Std length code, 4 bits
  localparam int SS_RTR     = 20; // Std remote flag
  localparam int SS_ID_LSB  = 21; // Std 11-bit id
  localparam int SS_DAT_LSB = 32; // Std data, 64 bits
  localparam int SE_DLC_LSB = 16; // Ext length code, 16 bits
  localparam int SE_ID_LSB  = 32; // Ext 29-bit id
  localparam int SE_RTR     = 62; // Ext remote flag
  localparam int SE_IDE     = 63; // Ext id type
  localparam int SE_DAT_LSB = 64; // Ext data, 64 bits

  // ------------------------------------------------------------
  // Normalised frame layout
  // ------------------------------------------------------------
  localparam int FR_DLC_LSB = 16; // 4 bits
  localparam int FR_RTR     = 20;
  localparam int FR_IDE     = 21;
  localparam int FR_ID_LSB  = 22; // 29 bits
  localparam int FR_DAT_LSB = 51; // 64 bits

  // Reset value of all counters and batch sizes
  localparam logic [15:0] CNT_RESET = 16'h0000;

  // Copy engine states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_COPY = 2'b01,
    ST_ACK  = 2'b10
  } ctq_state_e;
endpackage

//--- rtl/ctq_fifo_if.sv
`timescale 1ns/1ns
`default_nettype none
// Stream link into and out of the send FIFO
interface ctq_fifo_if #(parameter int W = 8);
  logic         in_valid;  // Source offers a word
  logic         in_ready;  // FIFO has room
  logic [W-1:0] in_data;   // Word in
  logic         out_valid; // FIFO not empty
  logic         out_ready; // Sink takes a word
  logic [W-1:0] out_data;  // Word out
  modport fifo (input in_valid, in_data, out_ready,
                output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready,
                input in_ready, out_valid, out_data);
endinterface
`default_nettype wire

//--- rtl/ctq_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module ctq_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Stream ports
  ctq_fifo_if.fifo  f
);
  localparam int AW = $clog2(D);

  // ------------------------------------------------------------
  // Storage and pointers
  // ------------------------------------------------------------
  logic [W-1:0] mem [D];      // Word storage, no reset needed
  logic [AW:0]  wr_ptr_reg;   // Write pointer with wrap bit
  logic [AW:0]  wr_ptr_next;
  logic [AW:0]  rd_ptr_reg;   // Read pointer with wrap bit
  logic [AW:0]  rd_ptr_next;
  logic         push;
  logic         pop;
  logic         full;
  logic         empty;

  // Full when pointers differ only in the wrap bit
  assign full  = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                 (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign empty = (wr_ptr_reg == rd_ptr_reg);
  assign f.in_ready  = !full;
  assign f.out_valid = !empty;
  assign f.out_data  = mem[rd_ptr_reg[AW-1:0]];
  assign push = f.in_valid && !full;
  assign pop  = f.out_ready && !empty;

  // Pointer advance
  always_comb begin
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    if (push) begin
      wr_ptr_next = wr_ptr_reg + 1'b1;
    end
    if (pop) begin
      rd_ptr_next = rd_ptr_reg + 1'b1;
    end
  end

  // Pointer registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
    end
  end

  // Word write; data needs no reset since empty guards it
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= f.in_data;
    end
  end
endmodule // ctq_fifo
`default_nettype wire

//--- rtl/ctq_top.sv
`timescale 1ns/1ns
`default_nettype none
module ctq_top (
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          rst_n,
  // Process image access
  input  wire logic          pi_wr,
  input  wire logic          pi_rd,
  input  wire logic [15:0]   pi_index,
  input  wire logic [7:0]    pi_subidx,
  input  wire logic [127:0]  pi_wdata,
  output logic      [127:0]  pi_rdata,
  output logic               pi_rvalid,
  // Gateway state
  input  wire logic          preop,
  input  wire logic          ext_queue_sel,
  input  wire logic [7:0]    map_max_subidx,
  // Receive linkage
  input  wire logic          rx_new_data,
  output logic               rx_publish,
  output logic      [15:0]   rx_counter,
  // CAN send side
  output logic               can_tx_valid,
  input  wire logic          can_tx_ready,
  output logic      [28:0]   can_tx_id,
  output logic               can_tx_ide,
  output logic               can_tx_rtr,
  output logic      [3:0]    can_tx_dlc,
  output logic      [63:0]   can_tx_data,
  // Status
  output logic      [15:0]   tx_done_counter,
  output logic      [15:0]   tx_txn
);
  localparam int FW = ctq_pkg::FRAME_W;
  localparam int AW = ctq_pkg::SLOT_AW;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [127:0] slot_mem [ctq_pkg::SLOT_DEPTH]; // Tx slots
  logic [15:0] req_reg   [2];  // Request counter per format
  logic [15:0] req_next  [2];
  logic [15:0] ack_reg   [2];  // Rx ack counter per format
  logic [15:0] ack_next  [2];
  logic [15:0] batch_reg [2];  // Batch size per format
  logic [15:0] batch_next[2];
  logic [15:0] done_reg  [2];  // Done counter per format
  logic [15:0] done_next [2];
  logic [15:0] rxc_reg   [2];  // Rx counter per format
  logic [15:0] rxc_next  [2];
  ctq_pkg::ctq_state_e st_reg, st_next; // Copy engine
  logic          fmt_reg, fmt_next;     // Format of batch
  logic [AW-1:0] idx_reg, idx_next;     // Slot being copied
  logic [AW:0]   n_reg, n_next;         // Frozen batch length
  logic          pend_reg, pend_next;   // Rx data waiting
  logic          pub_reg, pub_next;     // Publish pulse
  logic          ov_reg, ov_next;       // Output stage full
  logic [FW-1:0] of_reg, of_next;       // Output frame
  logic [15:0]   txn_reg, txn_next;     // Last sent txn
  logic [127:0]  rd_reg, rd_next;       // Read data
  logic          rv_reg, rv_next;       // Read valid

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  logic          q;           // Active format
  logic          hit_out;     // Access to active Tx object
  logic          hit_in;      // Access to active input object
  logic [7:0]    slot_cnt;    // Usable slots
  logic [7:0]    slot_sub;    // Slot number from sub-index
  logic          slot_wr;     // Accepted slot write
  logic [FW-1:0] frame;       // Slot under copy, normalised

  assign q = ext_queue_sel;
  // Only the object matching the format is reachable
  assign hit_out = pi_index == (q ? ctq_pkg::IDX_OUT_EXT
                                   : ctq_pkg::IDX_OUT_STD);
  assign hit_in  = pi_index == (q ? ctq_pkg::IDX_IN_EXT
                                   : ctq_pkg::IDX_IN_STD);
  assign slot_sub = pi_subidx - ctq_pkg::SUB_SLOT0;

  // Slot count is the mapped top sub-index minus three
  always_comb begin
    if (map_max_subidx < ctq_pkg::SUB_SLOT0) begin
      slot_cnt = 8'h00;
    end else if (map_max_subidx - 8'h03 > ctq_pkg::SLOT_DEPTH_8) begin
      slot_cnt = ctq_pkg::SLOT_DEPTH_8; // Storage limit
    end else begin
      slot_cnt = map_max_subidx - 8'h03;
    end
  end

  // Slot writes held off outside pre-operational
  assign slot_wr = pi_wr && hit_out && preop &&
                   pi_subidx >= ctq_pkg::SUB_SLOT0 &&
                   slot_sub < slot_cnt;

  // ------------------------------------------------------------
  // Slot to frame conversion
  // ------------------------------------------------------------
  function automatic logic [FW-1:0] to_frame(
    input logic [127:0] s,
    input logic         ext
  );
    logic [FW-1:0] f;
    logic [15:0]   dl;
    f = '0;
    f[15:0] = s[15:0]; // Transaction number
    if (ext) begin
      dl = s[ctq_pkg::SE_DLC_LSB +: 16];
      f[ctq_pkg::FR_RTR] = s[ctq_pkg::SE_RTR];
      f[ctq_pkg::FR_IDE] = s[ctq_pkg::SE_IDE];
      f[ctq_pkg::FR_ID_LSB +: 29] = s[ctq_pkg::SE_ID_LSB +: 29];
      f[ctq_pkg::FR_DAT_LSB +: 64] = s[ctq_pkg::SE_DAT_LSB +: 64];
    end else begin
      dl = {12'h000, s[ctq_pkg::SS_DLC_LSB +: 4]};
      f[ctq_pkg::FR_RTR] = s[ctq_pkg::SS_RTR];
      f[ctq_pkg::FR_ID_LSB +: 29] =
        {18'h00000, s[ctq_pkg::SS_ID_LSB +: 11]};
      f[ctq_pkg::FR_DAT_LSB +: 64] = s[ctq_pkg::SS_DAT_LSB +: 64];
    end
    // Out-of-range lengths saturate at eight bytes
    if (dl > ctq_pkg::DLC_MAX) begin
      dl = ctq_pkg::DLC_MAX;
    end
    f[ctq_pkg::FR_DLC_LSB +: 4] = dl[3:0];
    return f;
  endfunction

  assign frame = to_frame(slot_mem[idx_reg], fmt_reg);

  // ------------------------------------------------------------
  // Send FIFO
  // ------------------------------------------------------------
  ctq_fifo_if #(.W(FW)) sq ();

  ctq_fifo #(
    .W (FW),
    .D (ctq_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock (clock),
    .rst_n (rst_n),
    .f     (sq)
  );

  // Engine stalls on a full FIFO; output stage stalls on CAN side
  assign sq.in_valid  = (st_reg == ctq_pkg::ST_COPY);
  assign sq.in_data   = frame;
  assign sq.out_ready = !ov_reg || can_tx_ready;

  // ------------------------------------------------------------
  // Counters and batch size
  // ------------------------------------------------------------
  always_comb begin
    req_next   = req_reg;
    ack_next   = ack_reg;
    batch_next = batch_reg;
    if (pi_wr && hit_out) begin
      case (pi_subidx)
        ctq_pkg::SUB_CNT1: begin
          req_next[q] = pi_wdata[15:0];
        end
        ctq_pkg::SUB_CNT2: begin
          ack_next[q] = pi_wdata[15:0];
        end
        ctq_pkg::SUB_BATCH: begin
          // Ignored while a batch is outstanding
          if (req_reg[q] == done_reg[q]) begin
            batch_next[q] = pi_wdata[15:0];
          end
        end
        default: begin
          batch_next = batch_reg; // Slots or unused
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Copy engine
  // ------------------------------------------------------------
  always_comb begin
    st_next   = st_reg;
    fmt_next  = fmt_reg;
    idx_next  = idx_reg;
    n_next    = n_reg;
    done_next = done_reg;
    case (st_reg)
      ctq_pkg::ST_IDLE: begin
        // Equality only, so wrap needs no care
        if (req_reg[q] != done_reg[q]) begin
          fmt_next = q;
          idx_next = '0;
          // Clamp into one..slot count
          if (slot_cnt == 8'h00) begin
            n_next  = '0;
            st_next = ctq_pkg::ST_ACK; // Nothing to send
          end else begin
            if (batch_reg[q] == 16'h0000) begin
              n_next = 6'h01;
            end else if (batch_reg[q] > {8'h00, slot_cnt}) begin
              n_next = slot_cnt[AW:0];
            end else begin
              n_next = batch_reg[q][AW:0];
            end
            st_next = ctq_pkg::ST_COPY;
          end
        end
      end
      ctq_pkg::ST_COPY: begin
        if (sq.in_ready) begin
          if ({1'b0, idx_reg} == n_reg - 1'b1) begin
            st_next = ctq_pkg::ST_ACK;
          end else begin
            idx_next = idx_reg + 1'b1;
          end
        end
      end
      ctq_pkg::ST_ACK: begin
        // Whole batch now sits in the send queue
        done_next[fmt_reg] = done_reg[fmt_reg] + 16'h0001;
        st_next = ctq_pkg::ST_IDLE;
      end
      default: begin
        st_next = ctq_pkg::ST_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Receive counter
  // ------------------------------------------------------------
  always_comb begin
    rxc_next  = rxc_reg;
    pub_next  = 1'b0;
    // New data sets pending unless it is consumed now
    pend_next = pend_reg || rx_new_data;
    if ((pend_reg || rx_new_data) &&
        rxc_reg[q] == ack_reg[q]) begin
      rxc_next[q] = rxc_reg[q] + 16'h0001;
      pub_next    = 1'b1;
      pend_next   = pend_reg && rx_new_data;
    end
  end

  // ------------------------------------------------------------
  // Output stage and transaction report
  // ------------------------------------------------------------
  always_comb begin
    ov_next  = ov_reg;
    of_next  = of_reg;
    txn_next = txn_reg;
    if (ov_reg && can_tx_ready) begin
      txn_next = of_reg[15:0];
      ov_next  = 1'b0;
    end
    if (sq.out_ready && sq.out_valid) begin
      of_next = sq.out_data;
      ov_next = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  always_comb begin
    rd_next = '0;
    rv_next = pi_rd;
    if (pi_rd && hit_out) begin
      case (pi_subidx)
        ctq_pkg::SUB_COUNT: rd_next[7:0]  = map_max_subidx;
        ctq_pkg::SUB_CNT1:  rd_next[15:0] = req_reg[q];
        ctq_pkg::SUB_CNT2:  rd_next[15:0] = ack_reg[q];
        ctq_pkg::SUB_BATCH: rd_next[15:0] = batch_reg[q];
        default: begin
          if (slot_sub < slot_cnt) begin
            rd_next = slot_mem[slot_sub[AW-1:0]];
          end
        end
      endcase
    end else if (pi_rd && hit_in) begin
      case (pi_subidx)
        ctq_pkg::SUB_CNT1: rd_next[15:0] = done_reg[q];
        ctq_pkg::SUB_CNT2: rd_next[15:0] = rxc_reg[q];
        ctq_pkg::SUB_TXN:  rd_next[15:0] = txn_reg;
        default:           rd_next = '0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 2; i++) begin
        req_reg[i]   <= ctq_pkg::CNT_RESET;
        ack_reg[i]   <= ctq_pkg::CNT_RESET;
        batch_reg[i] <= ctq_pkg::CNT_RESET;
        done_reg[i]  <= ctq_pkg::CNT_RESET;
        rxc_reg[i]   <= ctq_pkg::CNT_RESET;
      end
      st_reg   <= ctq_pkg::ST_IDLE;
      fmt_reg  <= 1'b0;
      idx_reg  <= '0;
      n_reg    <= '0;
      pend_reg <= 1'b0;
      pub_reg  <= 1'b0;
      ov_reg   <= 1'b0;
      of_reg   <= '0;
      txn_reg  <= ctq_pkg::CNT_RESET;
      rd_reg   <= '0;
      rv_reg   <= 1'b0;
    end else begin
      req_reg   <= req_next;
      ack_reg   <= ack_next;
      batch_reg <= batch_next;
      done_reg  <= done_next;
      rxc_reg   <= rxc_next;
      st_reg    <= st_next;
      fmt_reg   <= fmt_next;
      idx_reg   <= idx_next;
      n_reg     <= n_next;
      pend_reg  <= pend_next;
      pub_reg   <= pub_next;
      ov_reg    <= ov_next;
      of_reg    <= of_next;
      txn_reg   <= txn_next;
      rd_reg    <= rd_next;
      rv_reg    <= rv_next;
    end
  end

  // Slot storage, only low 96 bits matter for std slots
  always_ff @(posedge clock) begin
    if (slot_wr) begin
      slot_mem[slot_sub[AW-1:0]] <= pi_wdata;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign pi_rdata        = rd_reg;
  assign pi_rvalid       = rv_reg;
  assign rx_publish      = pub_reg;
  assign rx_counter      = rxc_reg[q];
  assign can_tx_valid    = ov_reg;
  assign can_tx_id       = of_reg[ctq_pkg::FR_ID_LSB +: 29];
  assign can_tx_ide      = of_reg[ctq_pkg::FR_IDE];
  assign can_tx_rtr      = of_reg[ctq_pkg::FR_RTR];
  assign can_tx_dlc      = of_reg[ctq_pkg::FR_DLC_LSB +: 4];
  assign can_tx_data     = of_reg[ctq_pkg::FR_DAT_LSB +: 64];
  assign tx_done_counter = done_reg[q];
  assign tx_txn          = txn_reg;
endmodule // ctq_top
`default_nettype wire

//--- test/ctq_top_props.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------
// Port checker for the Tx queue block
// ------------------------------------------------
module ctq_top_props (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst_n,
  // Process image and format
  input wire logic        pi_wr,
  input wire logic        pi_rd,
  input wire logic        pi_rvalid,
  input wire logic        ext_queue_sel,
  // Receive linkage
  input wire logic        rx_new_data,
  input wire logic        rx_publish,
  input wire logic [15:0] rx_counter,
  // Send side and status
  input wire logic        can_tx_valid,
  input wire logic        can_tx_ready,
  input wire logic [28:0] can_tx_id,
  input wire logic [3:0]  can_tx_dlc,
  input wire logic [63:0] can_tx_data,
  input wire logic [15:0] tx_done_counter,
  input wire logic [15:0] tx_txn
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Frame offered while the CAN side stalls
  sequence s_stall; can_tx_valid && !can_tx_ready; endsequence
  // Frame still offered, fields unchanged
  sequence s_held;
    can_tx_valid && $stable(can_tx_id) && $stable(can_tx_data)
      && $stable(can_tx_dlc);
  endsequence
  a_frame_hold: assert property (s_stall |=> s_held)
    else $error("frame changed while stalled");
  a_dlc_limit: assert property (
    can_tx_valid |-> can_tx_dlc <= 4'h8)
    else $error("length code above eight");
  // Format switch swaps counters, so only steady format is judged
  a_done_step: assert property (
    $changed(tx_done_counter) && $stable(ext_queue_sel) |->
    tx_done_counter == $past(tx_done_counter) + 16'h1)
    else $error("done counter jumped");
  a_rx_bump: assert property (
    rx_publish && $stable(ext_queue_sel) |->
    rx_counter == $past(rx_counter) + 16'h1)
    else $error("rx counter not bumped by one");
  a_rx_cause: assert property (
    rx_publish |-> $past(rx_new_data) || $past(pi_wr, 2))
    else $error("publish without cause");
  a_txn_cause: assert property (
    $changed(tx_txn) |-> $past(can_tx_valid && can_tx_ready))
    else $error("txn moved without a send");
  a_read_answer: assert property (pi_rd |=> pi_rvalid)
    else $error("read not answered");
  a_rvalid_pulse: assert property (pi_rvalid |-> $past(pi_rd))
    else $error("stray read answer");
  a_reset_quiet: assert property (
    $rose(rst_n) |-> !can_tx_valid && tx_done_counter == 16'h0)
    else $error("not quiet after reset");
endmodule // ctq_top_props
bind ctq_top ctq_top_props u_props (.clock(clock), .rst_n(rst_n),
  .pi_wr(pi_wr), .pi_rd(pi_rd), .pi_rvalid(pi_rvalid),
  .ext_queue_sel(ext_queue_sel), .rx_new_data(rx_new_data),
  .rx_publish(rx_publish), .rx_counter(rx_counter),
  .can_tx_valid(can_tx_valid), .can_tx_ready(can_tx_ready),
  .can_tx_id(can_tx_id), .can_tx_dlc(can_tx_dlc),
  .can_tx_data(can_tx_data), .tx_done_counter(tx_done_counter),
  .tx_txn(tx_txn));
`default_nettype wire

//--- test/ctq_can_sink.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------
// CAN send side model
// ------------------------------------------------
module ctq_can_sink (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Mode and handshake
  input  wire logic slow,
  output logic      can_tx_ready
);
  logic [7:0] lfsr_reg; // Stall pattern
  // Slow mode takes about one frame in four, backing up the FIFO
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lfsr_reg     <= 8'hA5;
      can_tx_ready <= 1'b0;
    end else begin
      lfsr_reg     <= {lfsr_reg[6:0],
                       lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
      can_tx_ready <= !slow || (lfsr_reg[0] && lfsr_reg[1]);
    end
  end
endmodule // ctq_can_sink
`default_nettype wire

//--- test/ctq_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
module ctq_top_tb;
  // ------------------------------------------------
  // Signals
  // ------------------------------------------------
  logic         clock, rst_n, pi_wr, pi_rd, preop, ext_queue_sel;
  logic         rx_new_data, pi_rvalid, rx_publish, slow;
  logic         can_tx_valid, can_tx_ready, can_tx_ide, can_tx_rtr;
  logic [15:0]  pi_index, rx_counter, tx_done_counter, tx_txn;
  logic [7:0]   pi_subidx, map_max_subidx;
  logic [127:0] pi_wdata, pi_rdata, q;
  logic [28:0]  can_tx_id;
  logic [3:0]   can_tx_dlc;
  logic [63:0]  can_tx_data;
  logic [31:0]  seed;              // Random state
  logic [98:0]  got[$], exp[$];    // Frames seen and expected
  logic [127:0] slot[32];          // Shadow of slot contents
  logic [15:0]  req[2];            // Request counter per format
  int           error_cnt, compares;

  ctq_top dut (.clock(clock), .rst_n(rst_n), .pi_wr(pi_wr), .pi_rd(pi_rd),
    .pi_index(pi_index), .pi_subidx(pi_subidx), .pi_wdata(pi_wdata),
    .pi_rdata(pi_rdata), .pi_rvalid(pi_rvalid), .preop(preop),
    .ext_queue_sel(ext_queue_sel), .map_max_subidx(map_max_subidx),
    .rx_new_data(rx_new_data), .rx_publish(rx_publish),
    .rx_counter(rx_counter), .can_tx_valid(can_tx_valid),
    .can_tx_ready(can_tx_ready), .can_tx_id(can_tx_id),
    .can_tx_ide(can_tx_ide), .can_tx_rtr(can_tx_rtr),
    .can_tx_dlc(can_tx_dlc), .can_tx_data(can_tx_data),
    .tx_done_counter(tx_done_counter), .tx_txn(tx_txn));
  ctq_can_sink u_sink (.clock(clock), .rst_n(rst_n), .slow(slow),
    .can_tx_ready(can_tx_ready));

  // ------------------------------------------------
  // Helpers
  // ------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // Frame a slot should produce; length saturates at eight
  function automatic logic [98:0] frame(input logic [127:0] s,
                                        input logic e);
    logic [15:0] d;
    d = e ? s[31:16] : {12'h000, s[19:16]};
    if (d > 16'h0008) d = 16'h0008;
    if (e) return {s[60:32], s[63], s[62], d[3:0], s[127:64]};
    return {18'h0, s[31:21], 1'b0, s[20], d[3:0], s[95:32]};
  endfunction
  task automatic chk(input logic [127:0] seen, input logic [127:0] want);
    compares++;
    if (seen !== want) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h want %h", $time, seen, want);
    end
  endtask
  // Write to the active output object
  task automatic wr(input logic [7:0] sub, input logic [127:0] d);
    @(posedge clock);
    pi_wr     <= 1'b1;
    pi_index  <= ext_queue_sel ? ctq_pkg::IDX_OUT_EXT : ctq_pkg::IDX_OUT_STD;
    pi_subidx <= sub;
    pi_wdata  <= d;
    @(posedge clock);
    pi_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] idx, input logic [7:0] sub);
    @(posedge clock);
    pi_rd     <= 1'b1;
    pi_index  <= idx;
    pi_subidx <= sub;
    @(posedge clock);
    pi_rd <= 1'b0;
    #1;
    chk(128'(pi_rvalid), 128'h1);
    q = pi_rdata;
  endtask
  // Random slots with legal length codes
  task automatic fill(input int n);
    for (int i = 0; i < n; i++) begin
      for (int w = 0; w < 4; w++) begin
        seed = xs(seed);
        slot[i][w*32 +: 32] = seed;
      end
      if (ext_queue_sel) slot[i][31:16] = 16'(seed % 9);
      else slot[i][19:16] = 4'(seed % 9);
      if (ext_queue_sel) slot[i][63] = 1'b1;
      else slot[i][127:96] = 32'h0;
      wr(8'(ctq_pkg::SUB_SLOT0 + 8'(i)), slot[i]);
    end
  endtask
  // Queue expected frames, then bump the request counter
  task automatic kick(input int n);
    for (int i = 0; i < n; i++) exp.push_back(frame(slot[i], ext_queue_sel));
    req[ext_queue_sel] = req[ext_queue_sel] + 16'h1;
    wr(ctq_pkg::SUB_CNT1, {112'h0, req[ext_queue_sel]});
  endtask
  // Wait for the batch to be copied and sent, then compare
  task automatic finish(input int n);
    int k;
    k = 0;
    while ((tx_done_counter !== req[ext_queue_sel] ||
            got.size() < exp.size()) && k < 2000) begin
      @(posedge clock);
      #1;
      k++;
    end
    chk(tx_done_counter, req[ext_queue_sel]);
    chk(128'(got.size()), 128'(exp.size()));
    while (exp.size() > 0 && got.size() > 0)
      chk(got.pop_front(), exp.pop_front());
    exp.delete();
    chk(tx_txn, slot[n-1][15:0]);
    rd(ext_queue_sel ? ctq_pkg::IDX_IN_EXT : ctq_pkg::IDX_IN_STD,
       ctq_pkg::SUB_TXN);
    chk(q[15:0], slot[n-1][15:0]);
  endtask
  task automatic rx_pulse;
    @(posedge clock);
    rx_new_data <= 1'b1;
    @(posedge clock);
    rx_new_data <= 1'b0;
    #1;
  endtask
  task automatic test_done;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ------------------------------------------------
  // Clock, monitor, watchdog
  // ------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // Record each frame taken by the CAN side
  always @(posedge clock) begin
    if (rst_n && can_tx_valid && can_tx_ready)
      got.push_back({can_tx_id, can_tx_ide, can_tx_rtr, can_tx_dlc,
                     can_tx_data});
  end
  initial begin
    repeat (60000) @(posedge clock);
    error_cnt++;
    test_done();
  end

  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial begin
    {rst_n, pi_wr, pi_rd, rx_new_data, ext_queue_sel, slow} = 6'h00;
    {pi_index, pi_subidx, pi_wdata} = '0;
    preop = 1'b1;
    map_max_subidx = 8'h23;
    seed = 32'h68a7;
    req[0] = 16'h0;
    req[1] = 16'h0;
    {error_cnt, compares} = '0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    // Full std batch of 32 slots through a stalling sink
    slow <= 1'b1;
    fill(32);
    wr(ctq_pkg::SUB_BATCH, 128'h20);
    kick(32);
    finish(32);
    $display("test 1 done");
    // Batch size write refused while counters differ
    wr(ctq_pkg::SUB_BATCH, 128'h8);
    kick(8);
    wr(ctq_pkg::SUB_BATCH, 128'h5);
    finish(8);
    rd(ctq_pkg::IDX_OUT_STD, ctq_pkg::SUB_BATCH);
    chk(q[15:0], 16'h0008);
    $display("test 2 done");
    // Slot write outside pre-operational state is dropped
    slow <= 1'b0;
    wr(ctq_pkg::SUB_BATCH, 128'h1);
    preop <= 1'b0;
    wr(ctq_pkg::SUB_SLOT0, ~slot[0]);
    kick(1);
    finish(1);
    preop <= 1'b1;
    $display("test 3 done");
    // Mapping gives three slots; oversize batch is clamped
    map_max_subidx <= 8'h06;
    wr(ctq_pkg::SUB_BATCH, 128'hFF);
    kick(3);
    finish(3);
    $display("test 4 done");
    // Extended queue selected by the flag
    ext_queue_sel <= 1'b1;
    map_max_subidx <= 8'h23;
    wr(ctq_pkg::SUB_BATCH, 128'h4);
    fill(4);
    kick(4);
    finish(4);
    $display("test 5 done");
    // Receive counter waits for the acknowledge
    rx_pulse();
    chk({rx_publish, rx_counter}, 17'h00001 | 17'h10000);
    rx_pulse();
    chk({rx_publish, rx_counter}, 17'h00001);
    wr(ctq_pkg::SUB_CNT2, 128'h1);
    repeat (2) @(posedge clock);
    #1;
    chk(rx_counter, 16'h0002);
    $display("test 6 done");
    test_done();
  end
endmodule // ctq_top_tb
`default_nettype wire
